//--- hdl/pfta_pkg.sv
// Constants, encodings and carrier types of the program flash table access unit.
package pfta_pkg;
   // ---------------------------------------------------------------
   // Register map (byte addresses on APB)
   // ---------------------------------------------------------------
   localparam logic [7:0] OFF_CTRL   = 8'h00;
   localparam logic [7:0] OFF_UNLOCK = 8'h04;
   localparam logic [7:0] OFF_LATCH  = 8'h08;
   localparam logic [7:0] OFF_PTR_LO = 8'h0c;
   localparam logic [7:0] OFF_PTR_HI = 8'h10;
   localparam logic [7:0] OFF_PTR_UP = 8'h14;
   localparam logic [7:0] OFF_TBLCMD = 8'h18;
   localparam logic [7:0] OFF_FLAGS  = 8'h1c;
   // ---------------------------------------------------------------
   // Field positions
   // ---------------------------------------------------------------
   localparam int B_SPACE = 7;
   localparam int B_CFG   = 6;
   localparam int B_ERASE = 4;
   localparam int B_ABORT = 3;
   localparam int B_PROGRAM_ENABLE_BIT  = 2;
   localparam int B_START = 1;
   localparam int B_FETCH = 0;
   localparam int B_DONE  = 4;
   localparam int B_OPWR  = 0;
   localparam int B_BUSY  = 7;
   // ---------------------------------------------------------------
   // Values and widths
   // ---------------------------------------------------------------
   localparam logic [7:0]  KEY_FIRST  = 8'h55;
   localparam logic [7:0]  KEY_SECOND = 8'haa;
   localparam int          PTR_W      = 22;
   localparam logic [20:0] LOW_ONE    = 21'h000001;
   localparam logic [2:0]  BLK8_ZERO  = 3'h0;
   localparam logic [5:0]  ROW64_ZERO = 6'h00;
   localparam int          HOLD_N     = 8;
   localparam logic [5:0]  UP_MASK    = 6'h3f;

   typedef enum logic [1:0] {
      PM_KEEP    = 2'h0,
      PM_POSTINC = 2'h1,
      PM_POSTDEC = 2'h2,
      PM_PREINC  = 2'h3
   } pfta_mode_e;

   // Gray path: idle -> read -> (back) and idle -> program -> idle.
   typedef enum logic [1:0] {
      ST_IDLE = 2'h0,
      ST_READ = 2'h1,
      ST_PROG = 2'h2
   } pfta_state_e;

   typedef struct packed {
      logic [PTR_W-1:0] addr;
      logic             cfg_space;
      logic             prog_space;
      logic             rd;
      logic             prog;
      logic             erase;
   } pfta_flash_req_s;
endpackage : pfta_pkg

//--- hdl/pfta_core.sv
// Table access unit: pointer, latch, holding registers and timed write/erase control.
//
// How it works
// [R1] Byte reads, 8-byte programs, 64-byte erases.
// [R2] No bulk erase from running code.
// [R3] Instruction fetch stalls during write/erase.
// [R4] Any content stored; invalid opcodes become no-ops.
// [R5] All transfers pass through the byte latch.
// [R6] Table write fills holding register only.
// [R7] Table data needs no word alignment.
// [R8] Unlock port has no storage, reads zero.
// [R9] Space bit selects flash or data EEPROM.
// [R10] Config bit overrides space select when set.
// [R11] Erase enable erases row, clears when done.
// [R12] Enable bit gates cycles, cleared at power-up.
// [R13] Abort flag set at start, cleared on completion.
// [R14] Abort keeps space selects for tracing.
// [R15] Start bit set-only, hardware clears it.
// [R16] Completion sets done flag; software clears.
// [R17] Fetch bit one-cycle, refused with space selects.
// [R18] Pointer is 22 bits from three bytes.
// [R19] Four pointer actions per table operation.
// [R20] Auto update touches only low 21 bits.
// [R21] Table read uses all 22 pointer bits.
// [R22] Bits 2:0 pick holding register; 21:3 block.
// [R23] Erase uses bits 21:6, ignores 5:0.
// [R24] Start only after 55h then AAh unlock.
// [R25] Bad start attempts start nothing.
`timescale 1ns/1ps
module pfta_core (
   input  wire logic                     i_sys_clk,
   input  wire logic                     i_rst,
   input  wire logic                     i_por,
   input  wire logic                     psel,
   input  wire logic                     penable,
   input  wire logic                     pwrite,
   input  wire logic [7:0]               paddr,
   input  wire logic [31:0]              pwdata,
   output logic      [31:0]              prdata,
   output logic                          pready,
   output logic                          pslverr,
   input  wire logic [7:0]               i_flash_rdata,
   input  wire logic                     i_flash_done,
   output pfta_pkg::pfta_flash_req_s     o_flash_req,
   output logic      [8*pfta_pkg::HOLD_N-1:0] o_flash_wdata,
   output logic                          o_fetch_stall,
   output logic                          o_ee_fetch,
   output logic                          o_nvm_done
);
   // ---------------------------------------------------------------
   // State
   // ---------------------------------------------------------------
   pfta_pkg::pfta_state_e      state_r, state_nxt;
   pfta_pkg::pfta_flash_req_s  req_r;
   logic [pfta_pkg::PTR_W-1:0] ptr_r;
   logic [7:0]                 latch_r;
   logic [7:0]                 hold_r [pfta_pkg::HOLD_N];
   logic                       space_r, cfg_r, erase_r, abort_r, program_enable_bit_r, start_r, fetch_r;
   logic                       done_r, key1_r, unlocked_r;
   logic                       pready_r, pslverr_r, stall_r;
   logic [31:0]                prdata_r;

   function automatic logic hit(input logic [7:0] a, input logic [7:0] off);
      hit = (a == off);
   endfunction : hit

   // ---------------------------------------------------------------
   // APB decode
   // ---------------------------------------------------------------
   wire       acc      = psel & penable & pready_r;
   wire       wr_acc   = acc & pwrite;
   wire       w_ctrl   = wr_acc & hit(paddr, pfta_pkg::OFF_CTRL);
   wire       w_unlock = wr_acc & hit(paddr, pfta_pkg::OFF_UNLOCK);
   wire       w_latch  = wr_acc & hit(paddr, pfta_pkg::OFF_LATCH);
   wire       w_lo     = wr_acc & hit(paddr, pfta_pkg::OFF_PTR_LO);
   wire       w_hi     = wr_acc & hit(paddr, pfta_pkg::OFF_PTR_HI);
   wire       w_up     = wr_acc & hit(paddr, pfta_pkg::OFF_PTR_UP);
   wire       w_cmd    = wr_acc & hit(paddr, pfta_pkg::OFF_TBLCMD);
   wire       w_flags  = wr_acc & hit(paddr, pfta_pkg::OFF_FLAGS);
   wire [7:0] wb       = pwdata[7:0];
   wire       mapped   = hit(paddr, pfta_pkg::OFF_CTRL) | hit(paddr, pfta_pkg::OFF_UNLOCK)
                       | hit(paddr, pfta_pkg::OFF_LATCH) | hit(paddr, pfta_pkg::OFF_PTR_LO)
                       | hit(paddr, pfta_pkg::OFF_PTR_HI) | hit(paddr, pfta_pkg::OFF_PTR_UP)
                       | hit(paddr, pfta_pkg::OFF_TBLCMD) | hit(paddr, pfta_pkg::OFF_FLAGS);
   wire [7:0] ctrl_rd  = {space_r, cfg_r, 1'b0, erase_r, abort_r, program_enable_bit_r, start_r, fetch_r};
   wire       busy     = (state_r != pfta_pkg::ST_IDLE);

   logic [7:0] rd_mux;
   always_comb begin
      rd_mux = 8'h00;
      // [R8] unlock reads zero
      if (hit(paddr, pfta_pkg::OFF_CTRL))   rd_mux = ctrl_rd;
      if (hit(paddr, pfta_pkg::OFF_LATCH))  rd_mux = latch_r;
      if (hit(paddr, pfta_pkg::OFF_PTR_LO)) rd_mux = ptr_r[7:0];
      if (hit(paddr, pfta_pkg::OFF_PTR_HI)) rd_mux = ptr_r[15:8];
      if (hit(paddr, pfta_pkg::OFF_PTR_UP)) rd_mux = {2'h0, ptr_r[21:16]};
      if (hit(paddr, pfta_pkg::OFF_TBLCMD)) rd_mux = {busy, 7'h00};
      if (hit(paddr, pfta_pkg::OFF_FLAGS))  rd_mux = {3'h0, done_r, 4'h0};
   end

   // One wait state: pready rises in the second access cycle.
   always_ff @(posedge i_sys_clk) begin
      if (i_rst | i_por) begin
         pready_r  <= 1'b0;
         pslverr_r <= 1'b0;
         prdata_r  <= 32'h0000_0000;
      end else begin
         pready_r  <= psel & penable & ~pready_r;
         pslverr_r <= psel & penable & ~pready_r & ~mapped;
         prdata_r  <= (psel & penable & ~pready_r & ~pwrite) ? {24'h000000, rd_mux} : 32'h0;
      end
   end

   // ---------------------------------------------------------------
   // Table pointer arithmetic
   // ---------------------------------------------------------------
   pfta_pkg::pfta_mode_e mode;
   assign mode = pfta_pkg::pfta_mode_e'(pwdata[2:1]);
   // [R20] low 21 bits only
   wire [21:0] ptr_inc = {ptr_r[21], ptr_r[20:0] + pfta_pkg::LOW_ONE};
   wire [21:0] ptr_dec = {ptr_r[21], ptr_r[20:0] - pfta_pkg::LOW_ONE};
   // [R19] pre-increment addresses new value
   wire [21:0] eff_addr = (mode == pfta_pkg::PM_PREINC) ? ptr_inc : ptr_r;
   wire        op_go    = w_cmd & ~busy;
   wire        op_write = pwdata[pfta_pkg::B_OPWR];

   logic [21:0] ptr_nxt;
   always_comb begin
      ptr_nxt = ptr_r;
      if (w_lo) ptr_nxt[7:0] = wb;
      if (w_hi) ptr_nxt[15:8] = wb;
      // [R18] three bytes form the pointer
      if (w_up) ptr_nxt[21:16] = wb[5:0] & pfta_pkg::UP_MASK;
      if (op_go) begin
         case (mode)
            pfta_pkg::PM_POSTINC: ptr_nxt = ptr_inc;
            pfta_pkg::PM_POSTDEC: ptr_nxt = ptr_dec;
            pfta_pkg::PM_PREINC:  ptr_nxt = ptr_inc;
            default:              ptr_nxt = ptr_r;
         endcase
      end
   end

   // ---------------------------------------------------------------
   // Start qualification
   // ---------------------------------------------------------------
   wire start_req = w_ctrl & wb[pfta_pkg::B_START] & ~start_r & ~busy;
   // [R24] ordered key pair; [R12] enable gates
   wire start_ok  = start_req & unlocked_r & program_enable_bit_r;
   wire do_erase  = erase_r & space_r & ~cfg_r;
   wire finish    = (state_r == pfta_pkg::ST_PROG) & i_flash_done;

   always_comb begin
      state_nxt = state_r;
      case (state_r)
         pfta_pkg::ST_IDLE: begin
            if (start_ok) state_nxt = pfta_pkg::ST_PROG;
            else if (op_go & ~op_write) state_nxt = pfta_pkg::ST_READ;
         end
         pfta_pkg::ST_READ: state_nxt = pfta_pkg::ST_IDLE;
         // [R3] stay until the timer ends it
         pfta_pkg::ST_PROG: if (i_flash_done) state_nxt = pfta_pkg::ST_IDLE;
         default:           state_nxt = pfta_pkg::ST_IDLE;
      endcase
   end

   always_ff @(posedge i_sys_clk) begin
      if (i_rst | i_por) begin
         state_r    <= pfta_pkg::ST_IDLE;
         ptr_r      <= '0;
         latch_r    <= 8'h00;
         key1_r     <= 1'b0;
         unlocked_r <= 1'b0;
         stall_r    <= 1'b0;
         req_r      <= '0;
      end else begin
         state_r <= state_nxt;
         ptr_r   <= ptr_nxt;
         stall_r <= (state_nxt == pfta_pkg::ST_PROG);
         // [R24] any other unlock write or control write disarms
         key1_r     <= w_unlock ? (wb == pfta_pkg::KEY_FIRST) : (key1_r & ~w_ctrl);
         unlocked_r <= w_unlock ? (key1_r & (wb == pfta_pkg::KEY_SECOND))
                                : (unlocked_r & ~w_ctrl);
         // [R5] the latch is the only byte path; [R4] data passes unfiltered
         if (state_r == pfta_pkg::ST_READ) latch_r <= i_flash_rdata;
         else if (w_latch)                 latch_r <= wb;
         req_r.rd <= 1'b0;
         if (op_go & ~op_write & ~start_ok) begin
            // [R21] read uses all 22 bits
            req_r.addr <= eff_addr;
            req_r.rd   <= 1'b1;
         end
         if (start_ok) begin
            // [R2] only row-sized erase exists here; [R23] row bits
            req_r.addr  <= do_erase ? {ptr_r[21:6], pfta_pkg::ROW64_ZERO}
                                    : {ptr_r[21:3], pfta_pkg::BLK8_ZERO};
            req_r.erase <= do_erase;
            // [R22] block from bits 21:3; [R1] 8-byte program
            req_r.prog  <= ~do_erase;
         end else if (finish) begin
            req_r.erase <= 1'b0;
            req_r.prog  <= 1'b0;
         end
         // [R9] [R10] routing of the access
         req_r.prog_space <= space_r & ~cfg_r;
         req_r.cfg_space  <= cfg_r;
      end
   end

   // ---------------------------------------------------------------
   // Holding registers
   // ---------------------------------------------------------------
   genvar g;
   generate
      for (g = 0; g < pfta_pkg::HOLD_N; g++) begin : g_hold
         always_ff @(posedge i_sys_clk) begin
            if (i_por) begin
               hold_r[g] <= 8'h00;
            // [R6] [R22] [R7] byte goes to the holding slot only
            end else if (op_go & op_write & (eff_addr[2:0] == 3'(g))) begin
               hold_r[g] <= latch_r;
            end
         end
         assign o_flash_wdata[8*g +: 8] = hold_r[g];
      end
   endgenerate

   // ---------------------------------------------------------------
   // Control and flag bits
   // ---------------------------------------------------------------
   // A warm reset mid-cycle leaves the abort flag and selects behind, so
   // software can see which memory the lost cycle aimed at.
   always_ff @(posedge i_sys_clk) begin
      if (i_por) begin
         space_r <= 1'b0;
         cfg_r   <= 1'b0;
         abort_r <= 1'b0;
      end else begin
         // [R14] selects survive a warm reset
         if (~i_rst & w_ctrl) begin
            space_r <= wb[pfta_pkg::B_SPACE];
            cfg_r   <= wb[pfta_pkg::B_CFG];
         end
         // [R13] set at start or bad attempt, cleared by the timer
         if (i_rst) abort_r <= abort_r | busy;
         else if (start_req) abort_r <= 1'b1;
         else if (finish) abort_r <= 1'b0;
         else if (w_ctrl) abort_r <= wb[pfta_pkg::B_ABORT];
      end
   end

   always_ff @(posedge i_sys_clk) begin
      if (i_rst | i_por) begin
         erase_r <= 1'b0;
         program_enable_bit_r  <= 1'b0;
         start_r <= 1'b0;
         fetch_r <= 1'b0;
         done_r  <= 1'b0;
      end else begin
         // [R11] erase enable clears when the erase ends
         if (finish & req_r.erase) erase_r <= 1'b0;
         else if (w_ctrl & ~busy)  erase_r <= wb[pfta_pkg::B_ERASE];
         // [R12] software enable, cleared by reset
         if (w_ctrl) program_enable_bit_r <= wb[pfta_pkg::B_PROGRAM_ENABLE_BIT];
         // [R15] set-only; [R25] refused without unlock
         if (finish)        start_r <= 1'b0;
         else if (start_ok) start_r <= 1'b1;
         // [R17] one cycle, refused when the same write sets a select
         fetch_r <= w_ctrl & wb[pfta_pkg::B_FETCH] & ~fetch_r
                  & ~wb[pfta_pkg::B_SPACE] & ~wb[pfta_pkg::B_CFG];
         // [R16] set wins over a software clear
         if (finish) done_r <= 1'b1;
         else if (w_flags & ~wb[pfta_pkg::B_DONE]) done_r <= 1'b0;
      end
   end

   assign prdata        = prdata_r;
   assign pready        = pready_r;
   assign pslverr       = pslverr_r;
   assign o_flash_req   = req_r;
   assign o_fetch_stall = stall_r;
   assign o_ee_fetch    = fetch_r;
   assign o_nvm_done    = done_r;

   // ---------------------------------------------------------------
   // Assertions
   // ---------------------------------------------------------------
   a_ptr_top_keep: assert property (@(posedge i_sys_clk) disable iff (i_rst | i_por) // [R20]
      (op_go & ~w_up) |=> (ptr_r[21] == $past(ptr_r[21])))
      else $error("auto update changed pointer top bit");
   a_unlock_zero: assert property (@(posedge i_sys_clk) disable iff (i_rst | i_por) // [R8]
      (psel & penable & ~pready_r & ~pwrite & hit(paddr, pfta_pkg::OFF_UNLOCK))
      |=> (prdata == 32'h0))
      else $error("unlock port read nonzero");
   a_start_keyed: assert property (@(posedge i_sys_clk) disable iff (i_rst | i_por) // [R24]
      $rose(state_r == pfta_pkg::ST_PROG) |-> ($past(unlocked_r) && $past(program_enable_bit_r)))
      else $error("cycle started without unlock and enable");
   a_stall_prog: assert property (@(posedge i_sys_clk) disable iff (i_rst | i_por) // [R3]
      (o_fetch_stall == (state_r == pfta_pkg::ST_PROG)))
      else $error("fetch stall does not match cycle");
   a_abort_start: assert property (@(posedge i_sys_clk) disable iff (i_rst | i_por) // [R13]
      (state_r == pfta_pkg::ST_PROG) |-> (abort_r && start_r))
      else $error("abort or start flag low during cycle");
   a_done_flag: assert property (@(posedge i_sys_clk) disable iff (i_rst | i_por) // [R16]
      finish |=> (o_nvm_done && !start_r && !abort_r))
      else $error("completion did not set done flag");
   a_erase_row: assert property (@(posedge i_sys_clk) disable iff (i_rst | i_por) // [R23]
      o_flash_req.erase |-> (o_flash_req.addr[5:0] == 6'h00) && !o_flash_req.prog)
      else $error("erase address not row aligned");
   a_prog_block: assert property (@(posedge i_sys_clk) disable iff (i_rst | i_por) // [R22]
      $rose(o_flash_req.prog) |-> (o_flash_req.addr[21:3] == ptr_r[21:3]))
      else $error("program block not from pointer");
   a_fetch_pulse: assert property (@(posedge i_sys_clk) disable iff (i_rst | i_por) // [R17]
      o_ee_fetch |=> !o_ee_fetch)
      else $error("data fetch pulse longer than one cycle");
   a_read_latch: assert property (@(posedge i_sys_clk) disable iff (i_rst | i_por) // [R21]
      o_flash_req.rd |=> (latch_r == $past(i_flash_rdata)))
      else $error("read byte not latched");
endmodule : pfta_core

//--- tb/pfta_flash_model.sv
// Behavioural flash array and programming timer facing the table access unit.
`timescale 1ns/1ps
module pfta_flash_model #(
   parameter int PROG_CYCLES = 12
) (
   input  wire logic                      i_sys_clk,
   input  wire pfta_pkg::pfta_flash_req_s i_req,
   input  wire logic [63:0]               i_wdata,
   output logic      [7:0]                o_rdata,
   output logic                           o_done,
   output int                             o_cycles
);
   logic [7:0] mem_r [logic [21:0]];
   int         cnt_r;
   logic [7:0] junk_r;

   // Unwritten bytes hold a pattern derived from address bits 7:0 and 21.
   function automatic logic [7:0] peek(input logic [21:0] a);
      return mem_r.exists(a) ? mem_r[a] : (a[7:0] ^ 8'h3c ^ {a[21], 7'h00});
   endfunction : peek

   // The byte stands while the read request is up; otherwise the bus shows
   // toggling junk, so a latch taken in the wrong cycle is caught.
   assign o_rdata = (i_req.rd === 1'b1) ? peek(i_req.addr) : junk_r;

   initial begin
      junk_r   = 8'h5a;
      o_done   = 1'b0;
      o_cycles = 0;
      cnt_r    = 0;
   end

   always @(posedge i_sys_clk) begin
      junk_r  <= ~junk_r;
      o_done  <= 1'b0;
      if ((i_req.prog === 1'b1 || i_req.erase === 1'b1) && !o_done) begin
         cnt_r <= cnt_r + 1;
         if (cnt_r == PROG_CYCLES) begin
            cnt_r    <= 0;
            o_done   <= 1'b1;
            o_cycles <= o_cycles + 1;
            // Whole 8-byte block or 64-byte row only.
            if (i_req.erase === 1'b1) begin
               for (int i = 0; i < 64; i++) mem_r[{i_req.addr[21:6], 6'(i)}] = 8'hff;
            end else begin
               for (int i = 0; i < 8; i++) mem_r[{i_req.addr[21:3], 3'(i)}] = i_wdata[8*i +: 8];
            end
         end
      end else begin
         cnt_r <= 0;
      end
   end
endmodule : pfta_flash_model

//--- tb/test_pfta_core.sv
// Self-checking testbench of the table access unit over APB.
`timescale 1ns/1ps
module test_pfta_core;
   logic                      i_sys_clk = 1'b0;
   logic                      i_rst     = 1'b1;
   logic                      i_por     = 1'b1;
   logic                      psel      = 1'b0;
   logic                      penable   = 1'b0;
   logic                      pwrite    = 1'b0;
   logic [7:0]                paddr     = 8'h00;
   logic [31:0]               pwdata    = 32'h0;
   logic [31:0]               prdata;
   logic                      pready;
   logic                      pslverr;
   logic [7:0]                flash_rdata;
   logic                      flash_done;
   logic [63:0]               flash_wdata;
   logic                      fetch_stall;
   logic                      ee_fetch;
   logic                      nvm_done;
   pfta_pkg::pfta_flash_req_s flash_req;
   logic [31:0]               q;
   logic                      err;
   logic [1:0]                sel_seen;
   int                        fails = 0;
   int                        total_checks = 0;
   int                        prog_count;
   int                        pulses = 0;
   int                        n;

   always #25 i_sys_clk = ~i_sys_clk;
   always @(posedge i_sys_clk) begin
      if (ee_fetch === 1'b1) pulses++;
      if (flash_req.rd === 1'b1) sel_seen <= {flash_req.cfg_space, flash_req.prog_space};
   end

   pfta_core i_dut (.i_sys_clk(i_sys_clk), .i_rst(i_rst), .i_por(i_por), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
      .pready(pready), .pslverr(pslverr), .i_flash_rdata(flash_rdata),
      .i_flash_done(flash_done), .o_flash_req(flash_req), .o_flash_wdata(flash_wdata),
      .o_fetch_stall(fetch_stall), .o_ee_fetch(ee_fetch), .o_nvm_done(nvm_done));
   pfta_flash_model i_flash (.i_sys_clk(i_sys_clk), .i_req(flash_req), .i_wdata(flash_wdata),
      .o_rdata(flash_rdata), .o_done(flash_done), .o_cycles(prog_count));

   // ---------------------------------------------------------------
   // Shared tasks
   // ---------------------------------------------------------------
   task automatic give_verdict;
      $display("checks %0d mismatches %0d", total_checks, fails);
      if (fails == 0 && total_checks > 0) $display("All tests passed");
      else $display("Some tests failed");
      $finish;
   endtask : give_verdict

   task automatic chk(input logic [63:0] got, input logic [63:0] exp);
      total_checks++;
      if (got !== exp) begin
         fails++;
         $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : chk

   // Called just after a rising edge; holds the request until pready is sampled.
   task automatic apb(input logic w, input logic [7:0] a, input logic [7:0] d);
      int k;
      psel    <= 1'b1;
      pwrite  <= w;
      paddr   <= a;
      pwdata  <= {24'h0, d};
      @(posedge i_sys_clk);
      penable <= 1'b1;
      k = 0;
      do begin
         @(posedge i_sys_clk);
         k++;
      end while (pready !== 1'b1 && k < 20);
      q   = prdata;
      err = pslverr;
      psel    <= 1'b0;
      penable <= 1'b0;
      if (k >= 20) begin
         fails++;
         give_verdict();
      end
      @(posedge i_sys_clk);
   endtask : apb

   task automatic rdchk(input logic [7:0] a, input logic [7:0] exp);
      apb(1'b0, a, 8'h00);
      chk(q, {24'h0, exp});
   endtask : rdchk

   task automatic setptr(input logic [21:0] p);
      apb(1'b1, pfta_pkg::OFF_PTR_LO, p[7:0]);
      apb(1'b1, pfta_pkg::OFF_PTR_HI, p[15:8]);
      apb(1'b1, pfta_pkg::OFF_PTR_UP, {2'b00, p[21:16]});
   endtask : setptr

   task automatic ptrchk(input logic [21:0] p);
      rdchk(pfta_pkg::OFF_PTR_LO, p[7:0]);
      rdchk(pfta_pkg::OFF_PTR_HI, p[15:8]);
      rdchk(pfta_pkg::OFF_PTR_UP, {2'b00, p[21:16]});
   endtask : ptrchk

   task automatic tread(input logic [21:0] a, input logic [7:0] exp);
      setptr(a);
      apb(1'b1, pfta_pkg::OFF_TBLCMD, 8'h00);
      rdchk(pfta_pkg::OFF_LATCH, exp);
   endtask : tread

   // Software half of the start handshake: control, two keys, then start.
   task automatic start_cycle(input logic [7:0] ctl);
      apb(1'b1, pfta_pkg::OFF_CTRL, ctl);
      apb(1'b1, pfta_pkg::OFF_UNLOCK, pfta_pkg::KEY_FIRST);
      apb(1'b1, pfta_pkg::OFF_UNLOCK, pfta_pkg::KEY_SECOND);
      apb(1'b1, pfta_pkg::OFF_CTRL, ctl | 8'h02);
   endtask : start_cycle

   task automatic wait_idle;
      int k;
      k = 0;
      do begin
         apb(1'b0, pfta_pkg::OFF_TBLCMD, 8'h00);
         k++;
      end while (q[pfta_pkg::B_BUSY] !== 1'b0 && k < 40);
      if (k >= 40) begin
         fails++;
         give_verdict();
      end
   endtask : wait_idle

   function automatic logic [7:0] pat(input logic [21:0] a);
      return a[7:0] ^ 8'h3c ^ {a[21], 7'h00};
   endfunction : pat

   // ---------------------------------------------------------------
   // Main sequence
   // ---------------------------------------------------------------
   logic [21:0] p_start [5] = '{22'h3fffff, 22'h200000, 22'h000123, 22'h1fffff, 22'h000124};
   logic [21:0] p_at    [5] = '{22'h3fffff, 22'h200000, 22'h000123, 22'h000000, 22'h000125};
   logic [21:0] p_after [5] = '{22'h200000, 22'h3fffff, 22'h000123, 22'h000000, 22'h000125};
   logic [1:0]  p_mode  [5] = '{2'h1, 2'h2, 2'h0, 2'h3, 2'h3};

   initial begin
      repeat (4) @(posedge i_sys_clk);
      i_rst <= 1'b0;
      i_por <= 1'b0;
      @(posedge i_sys_clk);
      rdchk(pfta_pkg::OFF_CTRL, 8'h00);
      apb(1'b1, pfta_pkg::OFF_UNLOCK, pfta_pkg::KEY_FIRST);
      rdchk(pfta_pkg::OFF_UNLOCK, 8'h00);
      apb(1'b0, 8'h20, 8'h00);
      chk({q, 31'h0, err}, 64'h1);
      $display("test reset_map done");

      apb(1'b1, pfta_pkg::OFF_CTRL, 8'h80);
      for (int i = 0; i < 5; i++) begin
         setptr(p_start[i]);
         apb(1'b1, pfta_pkg::OFF_TBLCMD, {5'h0, p_mode[i], 1'b0});
         rdchk(pfta_pkg::OFF_LATCH, pat(p_at[i]));
         ptrchk(p_after[i]);
      end
      chk(sel_seen, 2'b01);
      apb(1'b1, pfta_pkg::OFF_CTRL, 8'hc0);
      tread(22'h000010, pat(22'h000010));
      chk(sel_seen, 2'b10);
      $display("test pointer_modes done");

      apb(1'b1, pfta_pkg::OFF_CTRL, 8'h84);
      setptr(22'h000107);
      for (int i = 0; i < 8; i++) begin
         apb(1'b1, pfta_pkg::OFF_LATCH, 8'ha0 + 8'(i));
         apb(1'b1, pfta_pkg::OFF_TBLCMD, 8'h07);
      end
      chk(flash_wdata, 64'ha7a6a5a4a3a2a1a0);
      chk(prog_count, 0);
      start_cycle(8'h84);
      chk(fetch_stall, 1'b1);
      rdchk(pfta_pkg::OFF_CTRL, 8'h8e);
      wait_idle();
      rdchk(pfta_pkg::OFF_CTRL, 8'h84);
      chk({fetch_stall, nvm_done}, 2'b01);
      rdchk(pfta_pkg::OFF_FLAGS, 8'h10);
      apb(1'b1, pfta_pkg::OFF_FLAGS, 8'h00);
      rdchk(pfta_pkg::OFF_FLAGS, 8'h00);
      tread(22'h000108, 8'ha0);
      tread(22'h00010f, 8'ha7);
      tread(22'h000110, pat(22'h000110));
      $display("test block_program done");

      setptr(22'h000125);
      start_cycle(8'h94);
      wait_idle();
      rdchk(pfta_pkg::OFF_CTRL, 8'h84);
      tread(22'h000100, 8'hff);
      tread(22'h00010c, 8'hff);
      tread(22'h00013f, 8'hff);
      tread(22'h000140, pat(22'h000140));
      $display("test row_erase done");

      n = prog_count;
      apb(1'b1, pfta_pkg::OFF_CTRL, 8'h86);
      chk(fetch_stall, 1'b0);
      start_cycle(8'h80);
      chk(fetch_stall, 1'b0);
      rdchk(pfta_pkg::OFF_CTRL, 8'h88);
      chk(prog_count, n);
      $display("test bad_start done");

      n = pulses;
      apb(1'b1, pfta_pkg::OFF_CTRL, 8'h01);
      @(posedge i_sys_clk);
      chk(pulses, n + 1);
      apb(1'b1, pfta_pkg::OFF_CTRL, 8'h81);
      apb(1'b1, pfta_pkg::OFF_CTRL, 8'h41);
      chk(pulses, n + 1);
      $display("test eeprom_fetch done");

      setptr(22'h000200);
      start_cycle(8'h84);
      i_rst <= 1'b1;
      repeat (2) @(posedge i_sys_clk);
      i_rst <= 1'b0;
      @(posedge i_sys_clk);
      apb(1'b0, pfta_pkg::OFF_CTRL, 8'h00);
      chk(q & 32'h88, 32'h88);
      $display("test warm_reset done");
      give_verdict();
   end
endmodule : test_pfta_core
